//--- rtl/lacs_axis.sv
// Register access over APB and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
module lacs_axis (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic full_step_pin,
  input wire lacs_pkg::lacs_motor_in_t motor_in,
  output lacs_pkg::lacs_motor_out_t motor_out
);

  typedef struct packed {
    // pin synchroniser and the level it has settled on
    logic [2:0] step_sync;
    logic step_seen;

    // config register
    logic filter_en;
    logic stop_en;
    logic [4:0] run_scale;
    logic [15:0] zero_wait;

    // regulation register
    logic [3:0] lower_limit;
    logic [3:0] upper_span;
    logic [1:0] up_code;
    logic [1:0] down_code;
    logic min_quarter;

    // velocity window of the regulation
    logic [22:0] low_vel;
    logic [22:0] high_vel;

    // load measurement and its four-sample filter
    logic [9:0] load_reading;
    logic [11:0] filter_sum;
    logic [1:0] filter_count;
    logic meas_valid;

    // stall stop, restart delay and the velocity shown to the ramp
    logic stall_event;
    logic stall_flag;
    logic stopped;
    logic [15:0] wait_count;
    logic [22:0] velocity;

    // current regulation
    logic [4:0] current_scale;
    logic [4:0] down_count;

    // bus read data, taken in the setup cycle
    logic [31:0] rdata;
  } lacs_state_t;

  // the whole axis state is one register
  lacs_state_t state_reg;
  lacs_state_t state_next;

  // current step from the helper module
  logic [4:0] scale_stepped;

  // pin and bus decode
  logic step_edge;
  logic apb_write;
  logic apb_read;

  // regulation terms
  logic [10:0] lower_thr;
  logic [10:0] upper_thr;
  logic [5:0] down_needed;
  logic regulate;
  logic below;
  logic above;
  logic do_up;
  logic do_down;

  // map the 2-bit decrement code to required measurement count
  function automatic logic [5:0] down_count_for(input logic [1:0] code);
    unique case (code)
      2'h0: down_count_for = 6'h20;
      2'h1: down_count_for = 6'h08;
      2'h2: down_count_for = 6'h02;
      2'h3: down_count_for = 6'h01;
    endcase
  endfunction

  // load thresholds are whole units of 32 readings; shared by both limits
  function automatic logic [10:0] load_units(input logic [4:0] units);
    load_units = {6'h00, units} << lacs_pkg::LOAD_SCALE_SHIFT;
  endfunction

  // one current update per fresh measurement
  lacs_current_step u_step (
    .scale(state_reg.current_scale),
    .run_scale(state_reg.run_scale),
    .min_quarter(state_reg.min_quarter),
    .do_up(do_up),
    .do_down(do_down),
    .up_code(state_reg.up_code),
    .scale_next(scale_stepped)
  );

  // apb decode: zero wait state, so pready is a plain term of the access phase
  assign apb_write = psel && penable && pwrite;
  assign apb_read = psel && penable && !pwrite;
  assign pready = psel && penable;
  assign prdata = state_reg.rdata;

  // no error response: unmapped reads return zero and writes to them vanish
  assign pslverr = 1'b0;

  // full-step pin passes three stages; a new level counts once stages two and three agree,
  // so a one-cycle glitch on the pin never makes a step
  assign step_edge = state_reg.step_sync[1] && state_reg.step_sync[2] && !state_reg.step_seen;

  // thresholds on the load reading
  always_comb begin
    lower_thr = load_units({1'h0, state_reg.lower_limit});
    upper_thr = load_units({1'h0, state_reg.lower_limit} + {1'h0, state_reg.upper_span} + 5'h01);
    down_needed = down_count_for(state_reg.down_code);

    // regulation runs only with a nonzero lower limit and inside the velocity window
    regulate = (state_reg.lower_limit != 4'h0)
      && (motor_in.ramp_velocity >= state_reg.low_vel)
      && (motor_in.ramp_velocity <= state_reg.high_vel);

    // where the fresh reading lies against the two thresholds
    below = {1'h0, state_reg.load_reading} < lower_thr;
    above = {1'h0, state_reg.load_reading} >= upper_thr;

    // up at once, down only after enough readings at or above the upper threshold
    do_up = state_reg.meas_valid && regulate && below;
    do_down = state_reg.meas_valid && regulate && above
      && ({1'h0, state_reg.down_count} + 6'h01 >= down_needed);
  end

  // all next-state logic of the axis
  always_comb begin
    state_next = state_reg;
    state_next.step_sync = {state_reg.step_sync[1:0], full_step_pin};
    state_next.meas_valid = 1'b0;
    // settled pin level; it moves only when stages two and three agree
    if (state_reg.step_sync[1] == state_reg.step_sync[2]) begin
      state_next.step_seen = state_reg.step_sync[2];
    end

    // measurement once per full step
    if (step_edge) begin
      if (!state_reg.filter_en) begin
        // unfiltered: every step publishes its own sample
        state_next.load_reading = motor_in.load_sample;
        state_next.meas_valid = 1'b1;
      end else begin
        // average of four samples, published every fourth step
        if (state_reg.filter_count == lacs_pkg::FILTER_STEPS) begin
          state_next.load_reading = 10'((state_reg.filter_sum + {2'h0, motor_in.load_sample}) >> 2);
          state_next.filter_sum = 12'h000;
          state_next.filter_count = 2'h0;
          state_next.meas_valid = 1'b1;
        end else begin
          state_next.filter_sum = state_reg.filter_sum + {2'h0, motor_in.load_sample};
          state_next.filter_count = state_reg.filter_count + 2'h1;
        end
      end
    end

    // adaptive current; decrement count resets on any non-above measurement
    if (state_reg.meas_valid) begin
      state_next.current_scale = scale_stepped;
      if (do_down || !above || !regulate) begin
        state_next.down_count = 5'h00;
      end else begin
        state_next.down_count = state_reg.down_count + 5'h01;
      end
    end
    // lower limit zero or run scale lowered: fall back to the run scale
    if (state_reg.lower_limit == 4'h0) begin
      state_next.current_scale = state_reg.run_scale;
    end else if (state_reg.current_scale > state_reg.run_scale) begin
      state_next.current_scale = state_reg.run_scale;
    end

    // zero-wait countdown after a re-arm
    // a count of zero means no restart is pending
    if (state_reg.wait_count != 16'h0000) begin
      state_next.wait_count = state_reg.wait_count - 16'h0001;
      if (state_reg.wait_count == 16'h0001) begin
        state_next.stopped = 1'b0;
      end
    end

    // register writes
    if (apb_write) begin
      unique case (paddr)
        lacs_pkg::ADDR_CONFIG: begin
          state_next.filter_en = pwdata[lacs_pkg::CFG_FILTER_BIT];
          state_next.stop_en = pwdata[lacs_pkg::CFG_STOP_BIT];
          state_next.run_scale = pwdata[lacs_pkg::CFG_RUN_LSB +: 5];
          state_next.zero_wait = pwdata[lacs_pkg::CFG_ZW_LSB +: 16];
          // a stale partial sum would spoil the first mean after the filter is toggled
          state_next.filter_sum = 12'h000;
          state_next.filter_count = 2'h0;
          if (!pwdata[lacs_pkg::CFG_STOP_BIT]) begin
            // turning stop-on-stall off releases the axis at once
            state_next.stopped = 1'b0;
            state_next.stall_event = 1'b0;
            state_next.wait_count = 16'h0000;
          end
        end
        lacs_pkg::ADDR_COOL: begin
          state_next.lower_limit = pwdata[lacs_pkg::COOL_MIN_LSB +: 4];
          state_next.upper_span = pwdata[lacs_pkg::COOL_SPAN_LSB +: 4];
          state_next.up_code = pwdata[lacs_pkg::COOL_UP_LSB +: 2];
          state_next.down_code = pwdata[lacs_pkg::COOL_DN_LSB +: 2];
          state_next.min_quarter = pwdata[lacs_pkg::COOL_SEIMIN_BIT];
          // a new rate restarts the count of readings toward a decrement
          state_next.down_count = 5'h00;
        end
        lacs_pkg::ADDR_VLOW: begin
          state_next.low_vel = pwdata[22:0];
        end
        lacs_pkg::ADDR_UPPER_VELOCITY_THRESHOLD: begin
          state_next.high_vel = pwdata[22:0];
        end
        // status offsets and holes ignore writes
        default: ;
      endcase
    end

    // reading ramp status clears the event and starts the zero-wait delay
    if (apb_read && paddr == lacs_pkg::ADDR_RAMP_STATUS && state_reg.stall_event) begin
      state_next.stall_event = 1'b0;
      state_next.stall_flag = 1'b0;
      if (state_reg.zero_wait == 16'h0000) begin
        state_next.stopped = 1'b0;
      end else begin
        state_next.wait_count = state_reg.zero_wait;
      end
    end

    // stall: zero reading on a fresh measurement; set wins over the clear above
    if (state_reg.meas_valid && state_reg.load_reading == 10'h000 && state_reg.stop_en) begin
      state_next.stall_event = 1'b1;
      state_next.stall_flag = 1'b1;
      state_next.stopped = 1'b1;
      state_next.wait_count = 16'h0000;
    end

    // velocity is registered so the output comes from a flop; a stop zeroes it in the same edge
    state_next.velocity = state_next.stopped ? 23'h000000 : motor_in.ramp_velocity;

    // read data captured in setup phase, shown during access
    // reads of holes and write cycles leave zero on the bus
    state_next.rdata = 32'h00000000;
    if (psel && !penable && !pwrite) begin
      unique case (paddr)
        lacs_pkg::ADDR_CONFIG: begin
          state_next.rdata[lacs_pkg::CFG_FILTER_BIT] = state_reg.filter_en;
          state_next.rdata[lacs_pkg::CFG_STOP_BIT] = state_reg.stop_en;
          state_next.rdata[lacs_pkg::CFG_RUN_LSB +: 5] = state_reg.run_scale;
          state_next.rdata[lacs_pkg::CFG_ZW_LSB +: 16] = state_reg.zero_wait;
        end
        lacs_pkg::ADDR_COOL: begin
          state_next.rdata[lacs_pkg::COOL_MIN_LSB +: 4] = state_reg.lower_limit;
          state_next.rdata[lacs_pkg::COOL_SPAN_LSB +: 4] = state_reg.upper_span;
          state_next.rdata[lacs_pkg::COOL_UP_LSB +: 2] = state_reg.up_code;
          state_next.rdata[lacs_pkg::COOL_DN_LSB +: 2] = state_reg.down_code;
          state_next.rdata[lacs_pkg::COOL_SEIMIN_BIT] = state_reg.min_quarter;
        end
        lacs_pkg::ADDR_VLOW: begin
          state_next.rdata[22:0] = state_reg.low_vel;
        end
        lacs_pkg::ADDR_UPPER_VELOCITY_THRESHOLD: begin
          state_next.rdata[22:0] = state_reg.high_vel;
        end
        // status words are read only
        lacs_pkg::ADDR_RAMP_STATUS: begin
          state_next.rdata[0] = state_reg.stall_event;
          state_next.rdata[1] = state_reg.stopped;
        end
        lacs_pkg::ADDR_DRIVER_STATUS: begin
          state_next.rdata[lacs_pkg::DS_LOAD_LSB +: 10] = state_reg.load_reading;
          state_next.rdata[lacs_pkg::DS_STALL_BIT] = state_reg.stall_flag;
          state_next.rdata[lacs_pkg::DS_CS_LSB +: 5] = state_reg.current_scale;
        end
        default: ;
      endcase
    end
  end

  // single state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= '0;
      // run scale and load reading start at full scale
      state_reg.run_scale <= lacs_pkg::RUN_RESET;
      state_reg.zero_wait <= lacs_pkg::ZERO_WAIT_RESET;
      state_reg.low_vel <= lacs_pkg::VEL_RESET;
      state_reg.high_vel <= lacs_pkg::VEL_RESET;
      state_reg.load_reading <= lacs_pkg::LOAD_RESET;
      state_reg.current_scale <= lacs_pkg::RUN_RESET;
      state_reg.velocity <= lacs_pkg::VEL_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // stopped axis reports zero velocity and asks the ramp to halt
  always_comb begin
    motor_out.stop_request = state_reg.stopped;
    motor_out.current_scale = state_reg.current_scale;
    motor_out.actual_velocity = state_reg.velocity;
    motor_out.load_reading = state_reg.load_reading;
  end

endmodule

//--- rtl/lacs_current_step.sv
`timescale 1ns/1ns
// one adaptive current update, pure combinational
module lacs_current_step (
  input wire logic [4:0] scale,
  input wire logic [4:0] run_scale,
  input wire logic min_quarter,
  input wire logic do_up,
  input wire logic do_down,
  input wire logic [1:0] up_code,
  output logic [4:0] scale_next
);

  logic [5:0] step;
  logic [5:0] floor_val;
  logic [6:0] sum;

  // a floor of zero would let the scale collapse; keep at least one step
  always_comb begin
    step = 6'h01 << up_code;
    floor_val = min_quarter ? {3'h0, run_scale[4:2]} : {2'h0, run_scale[4:1]};
    if (floor_val == 6'h00) begin
      floor_val = 6'h01;
    end
    sum = {2'h0, scale} + {1'h0, step};
    scale_next = scale;
    if (do_up) begin
      // saturate at the run current, never wrap
      scale_next = (sum > {2'h0, run_scale}) ? run_scale : sum[4:0];
    end else if (do_down) begin
      scale_next = ({1'h0, scale} > floor_val) ? 5'(scale - 5'h01) : floor_val[4:0];
    end
    if ({1'h0, scale_next} < floor_val) begin
      scale_next = floor_val[4:0];
    end
  end

endmodule

//--- rtl/lacs_pkg.sv
package lacs_pkg;

  // register byte offsets (APB, one aligned word each)
  localparam logic [7:0] ADDR_CONFIG = 8'h00;
  localparam logic [7:0] ADDR_COOL = 8'h04;
  localparam logic [7:0] ADDR_VLOW = 8'h08;
  localparam logic [7:0] ADDR_UPPER_VELOCITY_THRESHOLD = 8'h0c;
  localparam logic [7:0] ADDR_RAMP_STATUS = 8'h10;
  localparam logic [7:0] ADDR_DRIVER_STATUS = 8'h14;

  // config register field positions
  localparam int CFG_FILTER_BIT = 0;
  localparam int CFG_STOP_BIT = 1;
  localparam int CFG_RUN_LSB = 8;
  localparam int CFG_ZW_LSB = 16;
  // cool register field positions
  localparam int COOL_MIN_LSB = 0;
  localparam int COOL_SPAN_LSB = 8;
  localparam int COOL_UP_LSB = 12;
  localparam int COOL_DN_LSB = 16;
  localparam int COOL_SEIMIN_BIT = 20;
  // driver status field positions
  localparam int DS_LOAD_LSB = 0;
  localparam int DS_STALL_BIT = 15;
  localparam int DS_CS_LSB = 16;

  // reset values
  localparam logic [4:0] RUN_RESET = 5'h1f;
  localparam logic [15:0] ZERO_WAIT_RESET = 16'h0000;
  localparam logic [22:0] VEL_RESET = 23'h000000;
  localparam logic [9:0] LOAD_RESET = 10'h3ff;

  // scaling and filter counts
  localparam int LOAD_SCALE_SHIFT = 5;
  localparam logic [1:0] FILTER_STEPS = 2'h3;

  typedef struct packed {
    logic full_step;
    logic [9:0] load_sample;
    logic [22:0] ramp_velocity;
  } lacs_motor_in_t;

  typedef struct packed {
    logic stop_request;
    logic [4:0] current_scale;
    logic [22:0] actual_velocity;
    logic [9:0] load_reading;
  } lacs_motor_out_t;

endpackage

//--- verif/lacs_axis_bench.sv
`timescale 1ns/1ns
module lacs_axis_bench;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic full_step_pin;
  lacs_pkg::lacs_motor_in_t motor_in;
  lacs_pkg::lacs_motor_out_t motor_out;
  int err_total;
  int checks;
  logic [31:0] rd_data;
  logic [9:0] fl [4] = '{10'h064, 10'h0c8, 10'h12c, 10'h191};
  logic [5:0] nd [4] = '{6'h20, 6'h08, 6'h02, 6'h01};
  lacs_axis lacs_axis_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .full_step_pin(full_step_pin), .motor_in(motor_in), .motor_out(motor_out));
  lacs_motor_model lacs_motor_model_inst (.pclk(pclk), .full_step_pin(full_step_pin), .motor_in(motor_in));
  initial pclk = 1'b0;
  always #5 pclk = ~pclk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  // one apb transfer; the request stands until pready is seen at an edge
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd_data = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic scale_is(input logic [31:0] exp);
    chk(32'(motor_out.current_scale), exp);
  endtask
  task automatic conclude;
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // hang guard, far beyond the roughly 1500 cycles the run needs
  initial begin
    #200000;
    err_total++;
    conclude();
  end
  initial begin
    err_total = 0;
    checks = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    xfer(1'b0, 8'h14, 32'h0);
    chk(rd_data, 32'h001f03ff);
    xfer(1'b0, 8'h18, 32'h0);
    chk(rd_data, 32'h0);
    // filter from reset: one mean per four steps
    xfer(1'b1, 8'h00, 32'h00001f01);
    for (int i = 0; i < 4; i++) begin
      lacs_motor_model_inst.step(fl[i]);
      chk(32'(motor_out.load_reading), (i < 3) ? 32'h3ff : 32'h0fa);
    end
    xfer(1'b1, 8'h00, 32'h00001000);
    lacs_motor_model_inst.step(10'h04d);
    chk(32'(motor_out.load_reading), 32'h04d);
    scale_is(32'h10);
    lacs_motor_model_inst.speed(23'h000032);
    xfer(1'b1, 8'h08, 32'h0a);
    xfer(1'b1, 8'h0c, 32'h64);
    // every decrement rate, from full run scale each time
    for (int k = 0; k < 4; k++) begin
      xfer(1'b1, 8'h04, 32'h0);
      xfer(1'b1, 8'h04, 32'h00000102 | (32'(k) << 16));
      for (int j = 1; j <= 32'(nd[k]); j++) begin
        lacs_motor_model_inst.step(10'h0c8);
        scale_is((j < 32'(nd[k])) ? 32'h10 : 32'h0f);
      end
    end
    // every increment step, from the quarter floor
    for (int k = 0; k < 4; k++) begin
      xfer(1'b1, 8'h04, 32'h0);
      xfer(1'b1, 8'h04, 32'h00130102 | (32'(k) << 12));
      repeat (13) lacs_motor_model_inst.step(10'h0c8);
      scale_is(32'h04);
      lacs_motor_model_inst.step(10'h00a);
      scale_is(32'(4 + (1 << k)));
    end
    xfer(1'b1, 8'h04, 32'h0);
    xfer(1'b1, 8'h04, 32'h00030102);
    repeat (9) lacs_motor_model_inst.step(10'h0c8);
    scale_is(32'h08);
    lacs_motor_model_inst.speed(23'h000005);
    lacs_motor_model_inst.step(10'h00a);
    scale_is(32'h08);
    lacs_motor_model_inst.speed(23'h0000c8);
    lacs_motor_model_inst.step(10'h00a);
    scale_is(32'h08);
    lacs_motor_model_inst.speed(23'h000032);
    lacs_motor_model_inst.step(10'h064);
    scale_is(32'h08);
    lacs_motor_model_inst.step(10'h00a);
    scale_is(32'h09);
    // stall stop, armed by stop_en with a zero wait of five cycles
    xfer(1'b1, 8'h00, 32'h00051002);
    lacs_motor_model_inst.step(10'h000);
    chk(32'(motor_out.stop_request), 32'h1);
    chk(32'(motor_out.actual_velocity), 32'h0);
    xfer(1'b0, 8'h14, 32'h0);
    chk(32'(rd_data[15]), 32'h1);
    xfer(1'b0, 8'h10, 32'h0);
    chk(32'(rd_data[0]), 32'h1);
    chk(32'(rd_data[1]), 32'h1);
    @(posedge pclk);
    chk(32'(motor_out.stop_request), 32'h1);
    repeat (8) @(posedge pclk);
    chk(32'(motor_out.actual_velocity), 32'h32);
    xfer(1'b0, 8'h10, 32'h0);
    chk(32'(rd_data[0]), 32'h0);
    conclude();
  end
endmodule
bind lacs_axis lacs_axis_chk lacs_axis_chk_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .full_step_pin(full_step_pin), .motor_in(motor_in), .motor_out(motor_out));

//--- verif/lacs_axis_chk.sv
`timescale 1ns/1ns
// watches the axis ports; shadows the run scale from bus writes
module lacs_axis_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic full_step_pin,
  input wire lacs_pkg::lacs_motor_in_t motor_in,
  input wire lacs_pkg::lacs_motor_out_t motor_out
);
  logic pin_q;
  logic [3:0] since_rise;
  logic [4:0] run_sh;
  // age of the last step edge, saturating so a long pause never wraps
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_q <= 1'b0;
      since_rise <= 4'hf;
      run_sh <= lacs_pkg::RUN_RESET;
    end else begin
      pin_q <= full_step_pin;
      if (full_step_pin && !pin_q) since_rise <= 4'h0;
      else if (since_rise != 4'hf) since_rise <= since_rise + 4'h1;
      if (psel && penable && pwrite && paddr == lacs_pkg::ADDR_CONFIG) run_sh <= pwdata[lacs_pkg::CFG_RUN_LSB +: 5];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_access: assert property (pready == (psel && penable))
    else $error("pready off the access phase");
  a_no_slverr: assert property (pready |-> !pslverr)
    else $error("slave error raised");
  a_rdata_holds: assert property (!$past(psel && !penable && !pwrite) |-> prdata == 32'h00000000)
    else $error("read data shown outside a read access");
  a_vel_stopped: assert property (motor_out.stop_request |-> motor_out.actual_velocity == 23'h000000)
    else $error("velocity not zero while stopped");
  a_vel_follows: assert property (!motor_out.stop_request |-> motor_out.actual_velocity == $past(motor_in.ramp_velocity))
    else $error("velocity not following ramp");
  a_load_per_step: assert property ($changed(motor_out.load_reading) |-> since_rise <= 4'h6)
    else $error("load reading changed between steps");
  a_stall_zero: assert property ($rose(motor_out.stop_request) |-> motor_out.load_reading == 10'h000)
    else $error("stop without zero reading");
  a_scale_ceiling: assert property ($changed(motor_out.current_scale) |-> motor_out.current_scale <= run_sh)
    else $error("scale above run current");
endmodule

//--- verif/lacs_motor_model.sv
`timescale 1ns/1ns
// far side: the motor steps its shaft and reports load and ramp speed
module lacs_motor_model (
  input wire logic pclk,
  output logic full_step_pin,
  output lacs_pkg::lacs_motor_in_t motor_in
);
  initial begin
    full_step_pin = 1'b0;
    motor_in = '0;
  end
  // load holds well past the sync delay, then shows junk once stale
  task automatic step(input logic [9:0] ld);
    @(posedge pclk);
    motor_in.load_sample <= ld;
    full_step_pin <= 1'b1;
    motor_in.full_step <= 1'b1;
    repeat (6) @(posedge pclk);
    full_step_pin <= 1'b0;
    motor_in.full_step <= 1'b0;
    motor_in.load_sample <= ~ld;
    repeat (5) @(posedge pclk);
  endtask
  task automatic speed(input logic [22:0] v);
    @(posedge pclk);
    motor_in.ramp_velocity <= v;
  endtask
endmodule
